// file: design/twm_master.v
/*
 Two-wire bus master with its control, status, data and divider registers behind an AXI4-Lite slave.
 Assumes open-drain pads outside: an enable high pulls the line low, and both lines have pull-ups.
*/
// The implementer's own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "twm_defs.vh"

module twm_master #(
   parameter [15:0] DIVIDER_RESET = `TWM_RST_DIVIDER
) (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // AXI4-Lite write address and data
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   // AXI4-Lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // Two-wire bus pins
   input wire scl_in,
   output wire scl_out,
   output wire scl_oe,
   input wire sda_in,
   output wire sda_out,
   output wire sda_oe,
   // Interrupt request
   output wire irq
);

   localparam [3:0] S_IDLE = 4'h0;
   localparam [3:0] S_WAIT_FREE = 4'h1;
   localparam [3:0] S_START_A = 4'h2;
   localparam [3:0] S_START_B = 4'h3;
   localparam [3:0] S_START_C = 4'h4;
   localparam [3:0] S_HOLD = 4'h5;
   localparam [3:0] S_BIT_LOW = 4'h6;
   localparam [3:0] S_BIT_HIGH = 4'h7;
   localparam [3:0] S_BIT_END = 4'h8;
   localparam [3:0] S_STOP_A = 4'h9;
   localparam [3:0] S_STOP_B = 4'hA;
   localparam [3:0] S_STOP_C = 4'hB;
   localparam [3:0] S_RS_A = 4'hC;

   // Bus slave state.
   reg aw_full;
   reg w_full;
   reg [7:0] aw_addr;
   reg [31:0] w_data;
   reg [3:0] w_strb;
   // Software-owned control fields.
   reg ack_enable;
   reg start_request;
   reg unit_enable;
   reg irq_enable;
   reg [1:0] prescaler;
   reg [15:0] divider;
   // Engine-owned fields.
   reg done_flag;
   reg stop_request;
   reg write_collision;
   reg [7:0] serial_data_reg;
   reg [4:0] status_code;
   reg [3:0] state;
   reg [3:0] bit_cnt;
   reg [7:0] shift;
   reg addr_phase;
   reg master_receive;
   reg lost;
   reg restart;
   reg scl_low;
   reg sda_low;
   reg [15:0] tick_cnt;
   // Pin synchronisers and filtered levels.
   reg [2:0] scl_sync;
   reg [2:0] sda_sync;
   reg scl_f;
   reg sda_f;
   reg sda_prev;
   reg bus_busy;

   wire wr_go;
   wire ctrl_wr;
   wire data_wr;
   wire tick;
   wire drive_bit;
   wire [7:0] control_rd;

   assign s_axi_awready = !aw_full && !s_axi_bvalid;
   assign s_axi_wready = !w_full && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign wr_go = aw_full && w_full && !s_axi_bvalid;
   assign ctrl_wr = wr_go && (aw_addr == `TWM_OFS_CONTROL) && w_strb[0];
   assign data_wr = wr_go && (aw_addr == `TWM_OFS_DATA) && w_strb[0];
   assign tick = (tick_cnt == divider);
   assign control_rd = {done_flag, ack_enable, start_request, stop_request, write_collision, unit_enable, 1'b0,
      irq_enable};

   // Open drain: the pin only ever sinks, so the output value is fixed low.
   assign scl_out = 1'b0;
   assign sda_out = 1'b0;
   assign scl_oe = scl_low;
   assign sda_oe = sda_low;
   assign irq = done_flag && irq_enable;

   // Write channels are latched separately so address and data may arrive in either order.
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_full <= 1'b0;
         w_full <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `TWM_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (aw_addr == `TWM_OFS_CONTROL || aw_addr == `TWM_OFS_STATUS || aw_addr == `TWM_OFS_DATA ||
               aw_addr == `TWM_OFS_DIVIDER) begin
               s_axi_bresp <= `TWM_RESP_OKAY;
            end else begin
               s_axi_bresp <= `TWM_RESP_SLVERR;
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Read answer is registered one cycle after the address is taken.
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `TWM_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `TWM_RESP_OKAY;
         if (s_axi_araddr == `TWM_OFS_CONTROL) begin
            s_axi_rdata <= {24'h000000, control_rd};
         end else if (s_axi_araddr == `TWM_OFS_STATUS) begin
            s_axi_rdata <= {24'h000000, status_code, 1'b0, prescaler};
         end else if (s_axi_araddr == `TWM_OFS_DATA) begin
            s_axi_rdata <= {24'h000000, serial_data_reg};
         end else if (s_axi_araddr == `TWM_OFS_DIVIDER) begin
            s_axi_rdata <= {16'h0000, divider};
         end else begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `TWM_RESP_SLVERR;
         end
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Software-owned control fields and the divider.
   always @(posedge aclk) begin
      if (!aresetn) begin
         ack_enable <= 1'b0;
         start_request <= 1'b0;
         unit_enable <= 1'b0;
         irq_enable <= 1'b0;
         prescaler <= 2'h0;
         divider <= DIVIDER_RESET;
      end else if (wr_go) begin
         if (ctrl_wr) begin
            ack_enable <= w_data[`TWM_BIT_ACK_EN];
            start_request <= w_data[`TWM_BIT_START];
            unit_enable <= w_data[`TWM_BIT_ENABLE];
            irq_enable <= w_data[`TWM_BIT_IRQ_EN];
         end
         if (aw_addr == `TWM_OFS_STATUS && w_strb[0]) begin
            prescaler <= w_data[1:0];
         end
         if (aw_addr == `TWM_OFS_DIVIDER) begin
            if (w_strb[0]) begin
               divider[7:0] <= w_data[7:0];
            end
            if (w_strb[1]) begin
               divider[15:8] <= w_data[15:8];
            end
         end
      end
   end

   // A level counts once the second and third stages agree; the first stage feeds nothing else.
   always @(posedge aclk) begin
      if (!aresetn) begin
         scl_sync <= 3'h7;
         sda_sync <= 3'h7;
         scl_f <= 1'b1;
         sda_f <= 1'b1;
         sda_prev <= 1'b1;
         bus_busy <= 1'b0;
      end else begin
         scl_sync <= {scl_sync[1:0], scl_in};
         sda_sync <= {sda_sync[1:0], sda_in};
         if (scl_sync[1] == scl_sync[2]) begin
            scl_f <= scl_sync[2];
         end
         if (sda_sync[1] == sda_sync[2]) begin
            sda_f <= sda_sync[2];
         end
         sda_prev <= sda_f;
         if (scl_f && sda_prev && !sda_f) begin
            bus_busy <= 1'b1;
         end else if (scl_f && !sda_prev && sda_f) begin
            bus_busy <= 1'b0;
         end
      end
   end

   // Third-bit enable pulse; it free-runs so that each phase lasts divider plus one cycles.
   always @(posedge aclk) begin
      if (!aresetn || tick) begin
         tick_cnt <= 16'h0000;
      end else begin
         tick_cnt <= tick_cnt + 16'h0001;
      end
   end

   // Bit on the data line for the current slot; receive data bits and the address acknowledge are released.
   // Own acknowledge drives low.
   assign drive_bit = (bit_cnt == 4'h8) ? (master_receive && !addr_phase && ack_enable) : !shift[7];

   always @(posedge aclk) begin
      if (!aresetn || !unit_enable) begin
         done_flag <= 1'b0;
         stop_request <= 1'b0;
         write_collision <= 1'b0;
         serial_data_reg <= `TWM_RST_DATA;
         status_code <= `TWM_ST_IDLE;
         state <= S_IDLE;
         bit_cnt <= 4'h0;
         shift <= 8'h00;
         addr_phase <= 1'b0;
         master_receive <= 1'b0;
         lost <= 1'b0;
         restart <= 1'b0;
         scl_low <= 1'b0;
         sda_low <= 1'b0;
      end else begin
         if (ctrl_wr && w_data[`TWM_BIT_FLAG]) begin
            done_flag <= 1'b0;
         end
         if (ctrl_wr) begin
            stop_request <= w_data[`TWM_BIT_STOP];
         end
         if (data_wr) begin
            if (done_flag) begin
               serial_data_reg <= w_data[7:0];
               write_collision <= 1'b0;
            end else begin
               write_collision <= 1'b1;
            end
         end
         case (state)
            S_IDLE: begin
               if (start_request && !done_flag) begin
                  restart <= 1'b0;
                  state <= S_WAIT_FREE;
               end
            end
            S_WAIT_FREE: begin
               if (!bus_busy && tick) begin
                  state <= S_START_A;
               end
            end
            S_RS_A: begin
               if (tick) begin
                  sda_low <= 1'b0;
                  scl_low <= 1'b0;
                  restart <= 1'b1;
                  state <= S_START_A;
               end
            end
            S_START_A: begin
               if (tick && scl_f) begin
                  sda_low <= 1'b1;
                  state <= S_START_B;
               end
            end
            S_START_B: begin
               if (tick) begin
                  scl_low <= 1'b1;
                  state <= S_START_C;
               end
            end
            S_START_C: begin
               if (tick) begin
                  addr_phase <= 1'b1;
                  master_receive <= 1'b0;
                  lost <= 1'b0;
                  done_flag <= 1'b1;
                  status_code <= restart ? `TWM_ST_RSTART : `TWM_ST_START;
                  state <= S_HOLD;
               end
            end
            S_HOLD: begin
               // Bus stalled until the flag clears.
               if (!done_flag) begin
                  if (lost) begin
                     state <= start_request ? S_WAIT_FREE : S_IDLE;
                     restart <= 1'b0;
                  end else if (stop_request) begin
                     state <= S_STOP_A;
                  end else if (start_request) begin
                     state <= S_RS_A;
                  end else begin
                     shift <= (master_receive && !addr_phase) ? 8'hFF : serial_data_reg;
                     bit_cnt <= 4'h0;
                     state <= S_BIT_LOW;
                  end
               end
            end
            S_BIT_LOW: begin
               if (tick) begin
                  sda_low <= drive_bit;
                  state <= S_BIT_HIGH;
               end
            end
            S_BIT_HIGH: begin
               scl_low <= 1'b0;
               // Waiting for the line to read high lets a slave stretch the clock.
               if (tick && scl_f) begin
                  if (bit_cnt != 4'h8 && !sda_low && !sda_f && !(master_receive && !addr_phase)) begin
                     lost <= 1'b1;
                     sda_low <= 1'b0;
                     done_flag <= 1'b1;
                     status_code <= `TWM_ST_LOST;
                     state <= S_HOLD;
                  end else begin
                     if (bit_cnt == 4'h8) begin
                        restart <= sda_f;
                     end else begin
                        shift <= {shift[6:0], sda_f};
                     end
                     state <= S_BIT_END;
                  end
               end
            end
            S_BIT_END: begin
               if (tick) begin
                  scl_low <= 1'b1;
                  if (bit_cnt == 4'h8) begin
                     done_flag <= 1'b1;
                     addr_phase <= 1'b0;
                     state <= S_HOLD;
                     if (addr_phase) begin
                        master_receive <= serial_data_reg[0];
                        if (serial_data_reg[0]) begin
                           status_code <= restart ? `TWM_ST_AR_NACK : `TWM_ST_AR_ACK;
                        end else begin
                           status_code <= restart ? `TWM_ST_AW_NACK : `TWM_ST_AW_ACK;
                        end
                     end else if (master_receive) begin
                        serial_data_reg <= shift;
                        status_code <= ack_enable ? `TWM_ST_RX_ACK : `TWM_ST_RX_NACK;
                     end else begin
                        status_code <= restart ? `TWM_ST_TX_NACK : `TWM_ST_TX_ACK;
                     end
                     restart <= 1'b0;
                  end else begin
                     bit_cnt <= bit_cnt + 4'h1;
                     state <= S_BIT_LOW;
                  end
               end
            end
            S_STOP_A: begin
               if (tick) begin
                  sda_low <= 1'b1;
                  state <= S_STOP_B;
               end
            end
            S_STOP_B: begin
               if (tick) begin
                  scl_low <= 1'b0;
                  if (scl_f) begin
                     state <= S_STOP_C;
                  end
               end
            end
            S_STOP_C: begin
               if (tick) begin
                  sda_low <= 1'b0;
                  stop_request <= 1'b0;
                  master_receive <= 1'b0;
                  restart <= 1'b0;
                  status_code <= `TWM_ST_IDLE;
                  state <= start_request ? S_WAIT_FREE : S_IDLE;
               end
            end
            default: begin
               state <= S_IDLE;
            end
         endcase
      end
   end

endmodule // twm_master

// file: inc/twm_defs.vh
/*
 Constants of the two-wire master transmitter: register byte offsets, control bit positions, status codes,
 reset values and the default third-bit divider. Assumes a 200 MHz aclk and an AXI4-Lite register bus.
*/
`ifndef TWM_DEFS_VH
`define TWM_DEFS_VH

`define TWM_OFS_CONTROL 8'h00
`define TWM_OFS_STATUS 8'h04
`define TWM_OFS_DATA 8'h08
`define TWM_OFS_DIVIDER 8'h0C

`define TWM_BIT_FLAG 7
`define TWM_BIT_ACK_EN 6
`define TWM_BIT_START 5
`define TWM_BIT_STOP 4
`define TWM_BIT_WCOL 3
`define TWM_BIT_ENABLE 2
`define TWM_BIT_IRQ_EN 0

`define TWM_ST_START 5'h01
`define TWM_ST_RSTART 5'h02
`define TWM_ST_AW_ACK 5'h03
`define TWM_ST_AW_NACK 5'h04
`define TWM_ST_TX_ACK 5'h05
`define TWM_ST_TX_NACK 5'h06
`define TWM_ST_LOST 5'h07
`define TWM_ST_AR_ACK 5'h08
`define TWM_ST_AR_NACK 5'h09
`define TWM_ST_RX_ACK 5'h0A
`define TWM_ST_RX_NACK 5'h0B
`define TWM_ST_IDLE 5'h1F

`define TWM_RST_DIVIDER 16'h0005
`define TWM_RST_DATA 8'hFF
`define TWM_RESP_OKAY 2'h0
`define TWM_RESP_SLVERR 2'h2

`endif

// file: tb/twm_props.sv
/*
 Checker of the register bus handshakes, read error answers and bus stall of the two-wire master.
 Assumes it is bound to twm_master and sees only that module's ports.
*/
`timescale 1ns/1ps
`include "twm_defs.vh"
module twm_props (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // Register bus
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0] s_axi_rresp,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   // Bus pins and request
   input wire scl_oe,
   input wire sda_oe,
   input wire irq
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
   property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
   a_r_hold: assert property (p_r_hold) else $error("read answer dropped early");
   property p_b_lat; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
   endproperty
   a_b_lat: assert property (p_b_lat) else $error("write response late");
   property p_r_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_r_lat: assert property (p_r_lat) else $error("read answer late");
   property p_aw_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
   a_aw_block: assert property (p_aw_block) else $error("write taken during response");
   property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_ar_block: assert property (p_ar_block) else $error("read taken during answer");
   property p_rd_err; s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h0C
      |=> s_axi_rresp == `TWM_RESP_SLVERR && s_axi_rdata == 32'h00000000; endproperty
   a_rd_err: assert property (p_rd_err) else $error("unmapped read not refused");
   // Flag holds the bus still, allowing two cycles to settle.
   property p_stall; irq [*3] |-> $stable(scl_oe) && $stable(sda_oe); endproperty
   a_stall: assert property (p_stall) else $error("bus moved while flag set");
   cover property (irq [*3]);
   cover property (s_axi_bvalid && s_axi_bresp == `TWM_RESP_SLVERR);
   cover property (s_axi_rvalid && !s_axi_rready);
endmodule // twm_props

// file: tb/twm_slave.sv
/*
 Behavioural slave receiver on the two-wire bus: shifts in bytes, answers in the acknowledge slot.
 Assumes the bench resolves both open-drain lines with pull-ups; slow stretches every low clock phase.
*/
`timescale 1ns/1ps
module twm_slave (
   // Wire levels
   input wire scl,
   input wire sda,
   // Behaviour
   input wire nack,
   input wire slow,
   // Drives and observations
   output logic sda_oe = 1'h0,
   output logic scl_oe = 1'h0,
   output logic [7:0] last_byte = 8'h00,
   output int nstops = 0
);
   logic [7:0] sh = 8'h00;
   int bits = 0;
   always @(negedge sda) if (scl) bits = 0;
   always @(posedge sda) if (scl) nstops++;
   always @(posedge scl) if (bits < 8) begin
      sh = {sh[6:0], sda};
      bits++;
   end
   always @(negedge scl) begin
      if (bits == 8) begin
         last_byte = sh;
         sda_oe = !nack;
         bits = 9;
      end else if (bits == 9) begin
         sda_oe = 1'h0;
         bits = 0;
      end
      if (slow) begin
         scl_oe = 1'h1;
         #300 scl_oe = 1'h0;
      end
   end
endmodule // twm_slave

// file: tb/two_wire_master_transmit_test.sv
/*
 Self-checking bench of the two-wire master: register access, transmit flow, refusals and stop handling.
 Assumes the slave model and the checker beside the design; both lines have pull-ups.
*/
`timescale 1ns/1ps
`include "twm_defs.vh"
module two_wire_master_transmit_test;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
   logic s_axi_rready = 1'h0, sl_nack = 1'h0, sl_slow = 1'h0;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire scl_oe, sda_oe, irq, sl_scl_oe, sl_sda_oe;
   wire [7:0] sl_byte;
   int sl_stops;
   int error_cnt = 0;
   int cmp_count = 0;
   int n;
   wire scl_in = !(scl_oe || sl_scl_oe);
   wire sda_in = !(sda_oe || sl_sda_oe);
   twm_master twm_master_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .scl_in,
      .scl_out(), .scl_oe, .sda_in, .sda_out(), .sda_oe, .irq);
   twm_slave twm_slave_i (.scl(scl_in), .sda(sda_in), .nack(sl_nack), .slow(sl_slow), .sda_oe(sl_sda_oe),
      .scl_oe(sl_scl_oe), .last_byte(sl_byte), .nstops(sl_stops));
   always #2.5 aclk = !aclk;
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected at %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready);
      // A late bready lets the response wait, as a slow master would.
      repeat (2) @(posedge aclk);
      s_axi_bready <= 1'h1;
      do @(posedge aclk); while (!s_axi_bvalid);
      s_axi_bready <= 1'h0;
      chk({30'h0, s_axi_bresp}, {30'h0, er});
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'h0;
      @(posedge aclk);
      s_axi_rready <= 1'h1;
      do @(posedge aclk); while (!s_axi_rvalid);
      s_axi_rready <= 1'h0;
      chk(s_axi_rdata, e);
      chk({30'h0, s_axi_rresp}, {30'h0, er});
   endtask
   task automatic step(input logic [7:0] c, input logic [7:0] code);
      wr(`TWM_OFS_CONTROL, {24'h0, c}, `TWM_RESP_OKAY);
      do @(posedge aclk); while (!irq);
      rd(`TWM_OFS_STATUS, {24'h0, code}, `TWM_RESP_OKAY);
   endtask
   task automatic stop_end;
      n = sl_stops;
      wr(`TWM_OFS_CONTROL, 32'h95, `TWM_RESP_OKAY);
      wait (sl_stops != n);
      rd(`TWM_OFS_CONTROL, 32'h05, `TWM_RESP_OKAY);
      rd(`TWM_OFS_STATUS, 32'hF8, `TWM_RESP_OKAY);
   endtask
   task automatic t_regs;
      rd(`TWM_OFS_STATUS, 32'hF8, `TWM_RESP_OKAY);
      rd(`TWM_OFS_DATA, 32'hFF, `TWM_RESP_OKAY);
      rd(`TWM_OFS_DIVIDER, 32'h05, `TWM_RESP_OKAY);
      rd(8'h10, 32'h0, `TWM_RESP_SLVERR);
      wr(8'h10, 32'h0, `TWM_RESP_SLVERR);
      wr(`TWM_OFS_CONTROL, 32'h05, `TWM_RESP_OKAY);
      wr(`TWM_OFS_DATA, 32'h55, `TWM_RESP_OKAY);
      rd(`TWM_OFS_CONTROL, 32'h0D, `TWM_RESP_OKAY);
      rd(`TWM_OFS_DATA, 32'hFF, `TWM_RESP_OKAY);
      $display("test regs done");
   endtask
   task automatic t_tx;
      sl_slow = 1'h1;
      step(8'hA5, 8'h08);
      wr(`TWM_OFS_DATA, 32'hA4, `TWM_RESP_OKAY);
      step(8'h85, 8'h18);
      chk({24'h0, sl_byte}, 32'hA4);
      wr(`TWM_OFS_DATA, 32'h3C, `TWM_RESP_OKAY);
      step(8'h85, 8'h28);
      chk({24'h0, sl_byte}, 32'h3C);
      n = sl_stops;
      step(8'hA5, 8'h10);
      chk(sl_stops, n);
      wr(`TWM_OFS_DATA, 32'hA5, `TWM_RESP_OKAY);
      step(8'h85, 8'h40);
      chk({24'h0, sl_byte}, 32'hA5);
      stop_end;
      $display("test transmit done");
   endtask
   task automatic t_nack;
      sl_slow = 1'h0;
      sl_nack = 1'h1;
      step(8'hA5, 8'h08);
      wr(`TWM_OFS_DATA, 32'hA4, `TWM_RESP_OKAY);
      step(8'h85, 8'h20);
      wr(`TWM_OFS_DATA, 32'h11, `TWM_RESP_OKAY);
      step(8'h85, 8'h30);
      n = sl_stops;
      step(8'hB5, 8'h08);
      chk(sl_stops, n + 1);
      rd(`TWM_OFS_CONTROL, 32'hA5, `TWM_RESP_OKAY);
      stop_end;
      $display("test not acknowledge done");
   endtask
   task automatic summarize;
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'h1;
      t_regs;
      t_tx;
      t_nack;
      summarize;
   end
   initial begin
      #300000;
      error_cnt++;
      summarize;
   end
endmodule // two_wire_master_transmit_test
bind twm_master twm_props twm_props_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .scl_oe, .sda_oe, .irq);
